// ---- hdl/sfb_bit_exec.sv ----
// Combinational execution of one flag or bit operation
`timescale 1ns/10ps
module sfb_bit_exec
  import sfb_pkg::*;
(
  // Operation and operands
  input wire sfb_cmd_s cmd,
  input wire logic [7:0] dest,
  input wire logic [7:0] source,
  input wire sfb_flags_s flags,
  // Results
  output logic [7:0] nextDest,
  output sfb_flags_s nextFlags,
  output logic legalOp
);

  logic [7:0] flagVec;
  logic [7:0] shifted;

  always_comb begin
    flagVec = flags;
    shifted = {dest[7], dest[7:1]};
    nextDest = dest;
    nextFlags = flags;
    legalOp = 1'b1;
    unique case (cmd.op)
      SFB_OP_NONE: begin
        legalOp = 1'b0;
      end
      SFB_OP_SHIFT_RIGHT_ARITH: begin
        nextDest = shifted;
        nextFlags.carry = dest[0];
        nextFlags.negative = shifted[7];
        nextFlags.overflow = shifted[7] ^ dest[0];
        nextFlags.zero = ~|shifted;
      end
      SFB_OP_NIBBLE_SWAP: begin
        nextDest = {dest[3:0], dest[7:4]};
      end
      SFB_OP_FLAG_SET_BY_INDEX: begin
        flagVec[cmd.index] = 1'b1;
        nextFlags = sfb_flags_s'(flagVec);
      end
      SFB_OP_FLAG_CLEAR_BY_INDEX: begin
        flagVec[cmd.index] = 1'b0;
        nextFlags = sfb_flags_s'(flagVec);
      end
      SFB_OP_STORE_BIT_TO_TRANSFER_FLAG: begin
        nextFlags.transfer = source[cmd.index];
      end
      SFB_OP_LOAD_BIT_FROM_TRANSFER_FLAG: begin
        nextDest[cmd.index] = flags.transfer;
      end
      SFB_OP_SET_CARRY: begin
        nextFlags.carry = 1'b1;
      end
      SFB_OP_CLEAR_CARRY: begin
        nextFlags.carry = 1'b0;
      end
      SFB_OP_SET_NEGATIVE: begin
        nextFlags.negative = 1'b1;
      end
      SFB_OP_CLEAR_NEGATIVE: begin
        nextFlags.negative = 1'b0;
      end
      SFB_OP_SET_ZERO: begin
        nextFlags.zero = 1'b1;
      end
      SFB_OP_CLEAR_ZERO: begin
        nextFlags.zero = 1'b0;
      end
      SFB_OP_ENABLE_INTERRUPTS: begin
        nextFlags.glbIntr = 1'b1;
      end
      SFB_OP_DISABLE_INTERRUPTS: begin
        nextFlags.glbIntr = 1'b0;
      end
      SFB_OP_SET_SIGN: begin
        nextFlags.sign = 1'b1;
      end
      SFB_OP_CLEAR_SIGN: begin
        nextFlags.sign = 1'b0;
      end
      SFB_OP_SET_OVERFLOW: begin
        nextFlags.overflow = 1'b1;
      end
      SFB_OP_CLEAR_OVERFLOW: begin
        nextFlags.overflow = 1'b0;
      end
      SFB_OP_SET_TRANSFER: begin
        nextFlags.transfer = 1'b1;
      end
      default: begin
        // Unassigned codes leave everything as it was
        legalOp = 1'b0;
      end
    endcase
  end

endmodule

// ---- hdl/sfb_flag_bit_unit.sv ----
// APB-reached flag and bit operation unit with its destination, source and status registers
`timescale 1ns/10ps
`include "sfb_defines.svh"
module sfb_flag_bit_unit
  import sfb_pkg::*;
#(
  parameter int COUNT_W = `SFB_COUNT_W
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SFB_ADDR_W-1:0] paddr,
  input wire logic [`SFB_DATA_W-1:0] pwdata,
  output logic [`SFB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core-side view
  output logic [7:0] destValue,
  output sfb_flags_s statusValue,
  output logic opDone
);

  // Register state
  logic [7:0] destReg;
  logic [7:0] sourceReg;
  sfb_flags_s statusFlags;
  sfb_cmd_s lastCmd;
  logic [COUNT_W-1:0] opCount;
  logic [7:0] next_destReg;
  logic [7:0] next_sourceReg;
  sfb_flags_s next_statusFlags;
  sfb_cmd_s next_lastCmd;
  logic [COUNT_W-1:0] next_opCount;
  logic next_opDone;

  // Bus state
  logic [`SFB_DATA_W-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // Decode and execution
  logic setupPhase;
  logic writeNow;
  logic addrMapped;
  logic addrWritable;
  sfb_cmd_s cmdIn;
  logic [7:0] execDest;
  sfb_flags_s execFlags;
  logic execLegal;
  logic [`SFB_DATA_W-1:0] readWord;

  assign setupPhase = psel & ~penable;
  // A write lands only on the completing access edge and only if accepted at setup
  assign writeNow = psel & penable & pready & pwrite & ~pslverr;

  assign cmdIn.index = pwdata[`SFB_CMD_IDX_LSB +: `SFB_CMD_IDX_W];
  assign cmdIn.op = sfb_op_e'(pwdata[`SFB_CMD_OP_LSB +: `SFB_CMD_OP_W]);

  sfb_bit_exec exec (
    .cmd(cmdIn),
    .dest(destReg),
    .source(sourceReg),
    .flags(statusFlags),
    .nextDest(execDest),
    .nextFlags(execFlags),
    .legalOp(execLegal)
  );

  // Address decode and read mux
  always_comb begin
    addrMapped = 1'b1;
    addrWritable = 1'b1;
    readWord = '0;
    unique case (paddr)
      `SFB_OFS_DEST: begin
        readWord[7:0] = destReg;
      end
      `SFB_OFS_SOURCE: begin
        readWord[7:0] = sourceReg;
      end
      `SFB_OFS_COMMAND: begin
        readWord[`SFB_CMD_IDX_LSB +: `SFB_CMD_IDX_W] = lastCmd.index;
        readWord[`SFB_CMD_OP_LSB +: `SFB_CMD_OP_W] = lastCmd.op;
      end
      `SFB_OFS_STATUS: begin
        readWord[7:0] = statusFlags;
      end
      `SFB_OFS_COUNT: begin
        readWord[COUNT_W-1:0] = opCount;
        addrWritable = 1'b0;
      end
      default: begin
        addrMapped = 1'b0;
        addrWritable = 1'b0;
      end
    endcase
  end

  // Bus answer: ready in the first access cycle, data and error settled at setup
  always_comb begin
    next_pready = setupPhase;
    next_pslverr = 1'b0;
    next_prdata = '0;
    if (setupPhase) begin
      next_pslverr = pwrite ? ~addrWritable : ~addrMapped;
      if (!pwrite) begin
        next_prdata = readWord;
      end
    end
  end

  // Register writes and operation execution
  always_comb begin
    next_destReg = destReg;
    next_sourceReg = sourceReg;
    next_statusFlags = statusFlags;
    next_lastCmd = lastCmd;
    next_opCount = opCount;
    next_opDone = 1'b0;
    if (writeNow) begin
      unique case (paddr)
        `SFB_OFS_DEST: begin
          next_destReg = pwdata[7:0];
        end
        `SFB_OFS_SOURCE: begin
          next_sourceReg = pwdata[7:0];
        end
        `SFB_OFS_STATUS: begin
          next_statusFlags = sfb_flags_s'(pwdata[7:0]);
        end
        `SFB_OFS_COMMAND: begin
          // Whole operation completes on this one edge
          next_lastCmd = cmdIn;
          next_destReg = execDest;
          next_statusFlags = execFlags;
          if (execLegal) begin
            next_opDone = 1'b1;
            next_opCount = opCount + COUNT_W'(1);
          end
        end
        default: begin
          next_destReg = destReg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      destReg <= `SFB_RST_DEST;
      sourceReg <= `SFB_RST_SOURCE;
      statusFlags <= `SFB_RST_STATUS;
      lastCmd <= '0;
      opCount <= '0;
      opDone <= 1'b0;
      destValue <= `SFB_RST_DEST;
      statusValue <= `SFB_RST_STATUS;
    end else if (ce) begin
      destReg <= next_destReg;
      sourceReg <= next_sourceReg;
      statusFlags <= next_statusFlags;
      lastCmd <= next_lastCmd;
      opCount <= next_opCount;
      opDone <= next_opDone;
      destValue <= next_destReg;
      statusValue <= next_statusFlags;
    end
  end

endmodule

// ---- inc/sfb_defines.svh ----
// Register offsets, field positions and reset values of the flag and bit operation unit
//
// What this block does
// - Arithmetic shift right: bit n takes bit n+1, updates Z C N V, one cycle.
// - Nibble swap exchanges the destination halves, touches no flag, one cycle.
// - Indexed flag set writes one to the chosen status bit only, one cycle.
// - Indexed flag clear writes zero to the chosen status bit only, one cycle.
// - Bit store copies source bit b into the transfer flag only, one cycle.
// - Bit load copies the transfer flag into destination bit b, flags untouched.
// - Set and clear carry force only the carry flag, one cycle.
// - Set and clear negative force only the negative flag, one cycle.
// - Set and clear zero force only the zero flag, one cycle.
// - Interrupt enable sets, interrupt disable clears the global interrupt flag, one cycle.
// - Set and clear sign force only the signed-test flag, one cycle.
// - Set and clear overflow force only the overflow flag, one cycle.
// - Set transfer forces only the transfer flag to one, one cycle.
`ifndef SFB_DEFINES_SVH
`define SFB_DEFINES_SVH

`define SFB_ADDR_W 12
`define SFB_DATA_W 32

`define SFB_OFS_DEST 12'h000
`define SFB_OFS_SOURCE 12'h004
`define SFB_OFS_COMMAND 12'h008
`define SFB_OFS_STATUS 12'h00C
`define SFB_OFS_COUNT 12'h010

`define SFB_CMD_OP_LSB 0
`define SFB_CMD_OP_W 5
`define SFB_CMD_IDX_LSB 8
`define SFB_CMD_IDX_W 3

`define SFB_BYTE_W 8
`define SFB_COUNT_W 16

`define SFB_RST_DEST 8'h00
`define SFB_RST_SOURCE 8'h00
`define SFB_RST_STATUS 8'h00
`define SFB_RST_COUNT 16'h0000

`endif

// ---- inc/sfb_pkg.sv ----
// Types shared by the flag and bit operation unit
package sfb_pkg;

  typedef enum logic [4:0] {
    SFB_OP_NONE = 5'h00,
    SFB_OP_SHIFT_RIGHT_ARITH = 5'h01,
    SFB_OP_NIBBLE_SWAP = 5'h02,
    SFB_OP_FLAG_SET_BY_INDEX = 5'h03,
    SFB_OP_FLAG_CLEAR_BY_INDEX = 5'h04,
    SFB_OP_STORE_BIT_TO_TRANSFER_FLAG = 5'h05,
    SFB_OP_LOAD_BIT_FROM_TRANSFER_FLAG = 5'h06,
    SFB_OP_SET_CARRY = 5'h07,
    SFB_OP_CLEAR_CARRY = 5'h08,
    SFB_OP_SET_NEGATIVE = 5'h09,
    SFB_OP_CLEAR_NEGATIVE = 5'h0A,
    SFB_OP_SET_ZERO = 5'h0B,
    SFB_OP_CLEAR_ZERO = 5'h0C,
    SFB_OP_ENABLE_INTERRUPTS = 5'h0D,
    SFB_OP_DISABLE_INTERRUPTS = 5'h0E,
    SFB_OP_SET_SIGN = 5'h0F,
    SFB_OP_CLEAR_SIGN = 5'h10,
    SFB_OP_SET_OVERFLOW = 5'h11,
    SFB_OP_CLEAR_OVERFLOW = 5'h12,
    SFB_OP_SET_TRANSFER = 5'h13
  } sfb_op_e;

  // Bit 7 down to bit 0 of the status flags register
  typedef struct packed {
    logic glbIntr;
    logic transfer;
    logic halfCarry;
    logic sign;
    logic overflow;
    logic negative;
    logic zero;
    logic carry;
  } sfb_flags_s;

  typedef struct packed {
    logic [2:0] index;
    sfb_op_e op;
  } sfb_cmd_s;

endpackage

// ---- sim/sfb_flag_bit_unit_properties.sv ----
// Port checker for the flag and bit unit
`timescale 1ns/10ps
module sfb_flag_bit_unit_properties
  import sfb_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core view
  input wire logic [7:0] destValue,
  input wire sfb_flags_s statusValue,
  input wire logic opDone
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready too long");
  a_done_cause: assert property (opDone |-> $past(psel && penable && pready && pwrite) && $past(paddr) == 12'h008)
    else $error("done without command");
  a_shift_arith: assert property (opDone && $past(pwdata[4:0]) == 5'h01 |->
    destValue == {$past(destValue[7]), $past(destValue[7:1])} && statusValue.carry == $past(destValue[0]))
    else $error("shift wrong");
  a_swap_nibbles: assert property (opDone && $past(pwdata[4:0]) == 5'h02 |->
    destValue == {$past(destValue[3:0]), $past(destValue[7:4])} && statusValue == $past(statusValue))
    else $error("swap wrong");
  a_index_set: assert property (opDone && $past(pwdata[4:0]) == 5'h03 |->
    statusValue == ($past(statusValue) | (8'h01 << $past(pwdata[10:8]))))
    else $error("indexed set wrong");
  a_index_clear: assert property (opDone && $past(pwdata[4:0]) == 5'h04 |->
    statusValue == ($past(statusValue) & ~(8'h01 << $past(pwdata[10:8]))))
    else $error("indexed clear wrong");
  a_bit_load: assert property (opDone && $past(pwdata[4:0]) == 5'h06 |->
    destValue[$past(pwdata[10:8])] == $past(statusValue.transfer) && statusValue == $past(statusValue))
    else $error("bit load wrong");
  a_transfer_set: assert property (opDone && $past(pwdata[4:0]) == 5'h13 |->
    statusValue == ($past(statusValue) | 8'h40))
    else $error("transfer set wrong");
endmodule

// ---- sim/sfb_flag_bit_unit_test.sv ----
// Self-checking bench for the flag and bit unit
`timescale 1ns/10ps
module sfb_flag_bit_unit_test;
  import sfb_pkg::*;
  logic clk = 0, reset = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, opDone, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] destValue, s;
  sfb_flags_s statusValue;
  int n_errors = 0, n_checks = 0, cnt = 0;
  int pos[13] = '{0, 0, 2, 2, 1, 1, 7, 7, 4, 4, 3, 3, 6};
  always #4 clk = ~clk;
  sfb_flag_bit_unit DUT (.clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .destValue(destValue), .statusValue(statusValue), .opDone(opDone));
  task results;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    #1;
  endtask
  task op(input logic [4:0] o, input logic [2:0] b);
    xfer(1'b1, 12'h008, {21'h0, b, 3'h0, o});
    if (o inside {[5'h01:5'h13]}) cnt++;
  endtask
  task set(input logic [7:0] d, input logic [7:0] st);
    xfer(1'b1, 12'h000, {24'h0, d});
    xfer(1'b1, 12'h00C, {24'h0, st});
  endtask
  task t_reset;
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
      chk(err, 1'b0);
    end
  endtask
  task t_shift_swap;
    set(8'h81, 8'h30); op(5'h01, 3'h0); chk(destValue, 8'hC0); chk(statusValue, 8'h35);
    chk(opDone, 1'b1);
    set(8'h01, 8'h30); op(5'h01, 3'h0); chk(destValue, 8'h00); chk(statusValue, 8'h3B);
    set(8'h3C, 8'hA5); op(5'h02, 3'h0); chk(destValue, 8'hC3); chk(statusValue, 8'hA5);
  endtask
  task t_index;
    set(8'h00, 8'h00);
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      op(5'h03, 3'(i)); s[i] = 1'b1; chk(statusValue, s);
    end
    for (int i = 0; i < 8; i++) begin
      op(5'h04, 3'(i)); s[i] = 1'b0; chk(statusValue, s);
    end
  endtask
  task t_bits;
    set(8'h00, 8'h00); xfer(1'b1, 12'h004, 32'h20);
    op(5'h05, 3'h5); chk(statusValue, 8'h40);
    op(5'h06, 3'h0); chk(destValue, 8'h01); chk(statusValue, 8'h40);
    op(5'h05, 3'h4); chk(statusValue, 8'h00);
    xfer(1'b1, 12'h000, 32'hFF);
    op(5'h06, 3'h5); chk(destValue, 8'hDF);
  endtask
  task t_flags;
    set(8'h77, 8'h20);
    s = 8'h20;
    for (int i = 0; i < 13; i++) begin
      op(5'(7 + i), 3'h5); s[pos[i]] = (i % 2 == 0);
      chk(statusValue, s); chk(destValue, 8'h77);
    end
  endtask
  task t_refused;
    xfer(1'b1, 12'h010, 32'h1234); chk(err, 1'b1);
    xfer(1'b0, 12'h014, 32'h0); chk(err, 1'b1); chk(rd, 32'h0);
    set(8'h55, 8'hAA); op(5'h1F, 3'h0); chk(destValue, 8'h55); chk(statusValue, 8'hAA);
    chk(opDone, 1'b0);
    xfer(1'b0, 12'h008, 32'h0); chk(rd, 32'h0000001F);
    xfer(1'b0, 12'h00C, 32'h0); chk(rd, 32'hAA);
    xfer(1'b0, 12'h010, 32'h0); chk(rd, cnt);
  endtask
  task t_freeze;
    @(posedge clk);
    ce <= 1'b0; psel <= 1'b1; pwrite <= 1'b1; paddr <= 12'h000; pwdata <= 32'h0000005A;
    repeat (3) @(posedge clk);
    chk(pready, 1'b0); chk(destValue, 8'h55);
    ce <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    #1;
    chk(destValue, 8'h5A);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset; t_shift_swap; t_index; t_bits; t_flags; t_refused; t_freeze;
    results;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    results;
  end
endmodule
bind sfb_flag_bit_unit sfb_flag_bit_unit_properties u_props (.clk(clk), .reset(reset), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .destValue(destValue), .statusValue(statusValue), .opDone(opDone));
